// ---- core/embp_port.sv ----
// External memory bus port: address, data, strobes and bus hand-over.
// Assumes the core gives access requests synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module embp_port
  import embp_pkg::*;
#(
  parameter int AW = EMBP_AW,
  parameter int DW = EMBP_DW
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic acc_req_i,
  input wire logic acc_write_i,
  input wire logic acc_prog_i,
  input wire logic [AW-1:0] acc_addr_i,
  input wire logic [DW-1:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic rdata_valid_o,
  output logic [DW-1:0] rdata_o,
  output logic [1:0] phase_o,
  input wire logic bus_request_in_n_i,
  output logic bus_grant_out_n_o,
  output logic [AW-1:0] ext_address_o,
  output logic ext_address_oe_o,
  input wire logic [DW-1:0] ext_data_i,
  output logic [DW-1:0] ext_data_o,
  output logic ext_data_oe_o,
  output logic access_select_n_o,
  output logic space_select_o,
  output logic space_select_oe_o,
  output logic periph_space_enable_n_o,
  output logic periph_space_enable_n_oe_o,
  output logic read_strobe_n_o,
  output logic read_strobe_n_oe_o,
  output logic write_strobe_n_o,
  output logic write_strobe_n_oe_o
);
  embp_phase_if ph ();

  embp_phase_gen u_phase (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ph(ph)
  );

  logic req_s1_r;
  logic req_s2_r;
  logic granted_r;
  logic active_r;
  logic write_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic space_r;
  logic periph_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic drive_r;
  logic [DW-1:0] rdata_r;
  logic rvalid_r;
  logic start_nxt;
  logic in_periph;

  assign start_nxt = (ph.phase == EMBP_T3) && acc_req_i && !req_s2_r;
  assign in_periph = (acc_addr_i >= EMBP_PERIPH_LO) && (acc_addr_i <= EMBP_PERIPH_HI);

  // Bus request pin through two flip-flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= !bus_request_in_n_i;
      req_s2_r <= req_s1_r;
    end
  end

  // Grant only between accesses, at a cycle boundary
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      granted_r <= 1'b0;
    end else if (ph.t3_end) begin
      granted_r <= req_s2_r;
    end
  end

  // Access occupies one instruction cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
      write_r <= 1'b0;
      wdata_r <= EMBP_DATA_RST;
    end else if (ph.t3_end) begin
      active_r <= start_nxt;
      write_r <= acc_write_i;
      wdata_r <= acc_wdata_i;
    end
  end

  // Address, space and peripheral lines change entering T0
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_r <= EMBP_ADDR_RST;
      space_r <= 1'b1;
      periph_n_r <= 1'b1;
    end else if (ph.t3_end) begin
      if (start_nxt) begin
        addr_r <= acc_addr_i;
        space_r <= acc_prog_i;
        periph_n_r <= !(!acc_prog_i && in_periph);
      end else begin
        space_r <= 1'b1;
        periph_n_r <= 1'b1;
      end
    end
  end

  // Strobes: read low T1..T2, write low T1..T2, both high in T3
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end else begin
      rd_n_r <= !(active_r && !write_r && (ph.phase == EMBP_T0 || ph.phase == EMBP_T1));
      wr_n_r <= !(active_r && write_r && (ph.phase == EMBP_T0 || ph.phase == EMBP_T1));
    end
  end

  // Write data driven T2 to next T0
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= active_r && write_r && (ph.phase == EMBP_T1 || ph.phase == EMBP_T2);
    end
  end

  // Read capture at trailing edge of T2; bus is timed by our own strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_r <= EMBP_DATA_RST;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      if (active_r && !write_r && ph.phase == EMBP_T2) begin
        rdata_r <= ext_data_i;
        rvalid_r <= 1'b1;
      end
    end
  end

  assign acc_ready_o = ph.t3_end && !req_s2_r;
  assign rdata_valid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign phase_o = ph.phase;
  assign bus_grant_out_n_o = !granted_r;
  assign ext_address_o = addr_r;
  assign ext_address_oe_o = !granted_r;
  assign ext_data_o = wdata_r;
  assign ext_data_oe_o = drive_r && !granted_r;
  assign access_select_n_o = !(active_r && !granted_r && !rst_i);
  assign space_select_o = space_r;
  assign space_select_oe_o = !granted_r;
  assign periph_space_enable_n_o = periph_n_r;
  assign periph_space_enable_n_oe_o = !granted_r;
  assign read_strobe_n_o = rd_n_r;
  assign read_strobe_n_oe_o = !granted_r;
  assign write_strobe_n_o = wr_n_r;
  assign write_strobe_n_oe_o = !granted_r;
endmodule : embp_port
`default_nettype wire

// ---- core/embp_pkg.sv ----
// Constants and types for the external memory bus port.
// Assumes one 20 MHz core clock; one phase per clock edge.
// Functional notes
// - Address lines update in T0 with the current external access address.
// - Without an external access the address lines keep their last value.
// - Read data is captured at the trailing edge of T2.
// - Write data drives from leading T2, released at the next T0.
// - Data bus stays high impedance in cycles without bus activity.
// - Access select goes low whenever an external access is performed.
// - Access select is forced high during bus grant or reset.
// - Space select high for program, low for data, timed like the address.
// - Space select returns high at the T0 that starts an idle cycle.
// - Peripheral enable low only for data addresses FF00 to FF7F, set in T0.
// - Peripheral enable high for program accesses and out-of-range data accesses.
// - Write strobe goes low in T1; the data bus turns to output in T2.
// - Write strobe rises in T3; the far side latches data there.
// - Read strobe goes low early T1, data bus input, far side drives it.
// - Read strobe rises in T3 and the read data is kept.
// - Strobes qualify address and space select for the far side.
// - Strobes are high impedance whenever the port is not bus master.
// - Four phases T0 to T3 follow from the clock, one per edge.
// - A bus request leads to a grant a few phases later and release.
package embp_pkg;
  localparam int EMBP_AW = 16;
  localparam int EMBP_DW = 16;
  localparam logic [15:0] EMBP_PERIPH_LO = 16'hFF00;
  localparam logic [15:0] EMBP_PERIPH_HI = 16'hFF7F;
  localparam logic [15:0] EMBP_ADDR_RST = 16'h0000;
  localparam logic [15:0] EMBP_DATA_RST = 16'h0000;
  typedef enum logic [1:0] {
    EMBP_T0,
    EMBP_T1,
    EMBP_T2,
    EMBP_T3
  } embp_phase_t;
endpackage : embp_pkg

// ---- core/embp_phase_if.sv ----
// Phase timing carried from the phase generator to the port.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface embp_phase_if;
  import embp_pkg::*;
  embp_phase_t phase;
  logic t3_end;
  modport gen (output phase, output t3_end);
  modport use_p (input phase, input t3_end);
endinterface : embp_phase_if
`default_nettype wire

// ---- core/embp_phase_gen.sv ----
// Four-phase sequencer: one phase per core clock edge.
// Assumes synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module embp_phase_gen
  import embp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  embp_phase_if.gen ph
);
  embp_phase_t phase_r;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_r <= EMBP_T0;
    end else begin
      phase_r <= embp_phase_t'(phase_r + 2'h1);
    end
  end
  assign ph.phase = phase_r;
  assign ph.t3_end = (phase_r == EMBP_T3);
endmodule : embp_phase_gen
`default_nettype wire

// ---- dv/embp_assertions.sv ----
// Checker: phase, strobe, address and grant timing.
// Assumes binding to embp_port.
`timescale 1ns/1ps
`default_nettype none
module embp_assertions
  import embp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [1:0] phase_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_oe_o,
  input wire logic write_strobe_n_oe_o,
  input wire logic rdata_valid_o,
  input wire logic ext_data_oe_o,
  input wire logic [15:0] ext_address_o,
  input wire logic periph_space_enable_n_o,
  input wire logic space_select_o,
  input wire logic access_select_n_o,
  input wire logic bus_grant_out_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_phase_seq: assert property (phase_o == 2'h3 |=> phase_o == 2'h0 ##1 phase_o == 2'h1)
    else $error("phase order");
  a_wr_fall: assert property ($fell(write_strobe_n_o) |-> phase_o == 2'h1)
    else $error("write fall");
  a_wr_rise: assert property ($rose(write_strobe_n_o) |-> phase_o == 2'h3)
    else $error("write rise");
  a_rd_cycle: assert property ($fell(read_strobe_n_o) |-> phase_o == 2'h1
    ##2 $rose(read_strobe_n_o) && rdata_valid_o) else $error("read cycle");
  a_wdata_win: assert property ($rose(ext_data_oe_o) |-> phase_o == 2'h2
    ##1 ext_data_oe_o ##1 !ext_data_oe_o && phase_o == 2'h0) else $error("write data");
  a_addr_hold: assert property (phase_o != 2'h0 |-> $stable(ext_address_o))
    else $error("address moved");
  a_periph_rng: assert property (bus_grant_out_n_o && !periph_space_enable_n_o
    |-> !space_select_o && ext_address_o >= EMBP_PERIPH_LO && ext_address_o <= EMBP_PERIPH_HI)
    else $error("periph range");
  a_grant_off: assert property (!bus_grant_out_n_o |-> access_select_n_o
    && !read_strobe_n_oe_o && !write_strobe_n_oe_o) else $error("grant drive");
  c_read: cover property ($fell(read_strobe_n_o));
  c_write: cover property ($fell(write_strobe_n_o));
  c_grant: cover property ($fell(bus_grant_out_n_o));
endmodule : embp_assertions
bind embp_port embp_assertions u_chk (.clock_i, .rst_i, .phase_o, .read_strobe_n_o,
  .write_strobe_n_o, .read_strobe_n_oe_o, .write_strobe_n_oe_o, .rdata_valid_o,
  .ext_data_oe_o, .ext_address_o, .periph_space_enable_n_o, .space_select_o,
  .access_select_n_o, .bus_grant_out_n_o);
`default_nettype wire

// ---- dv/embp_mem_model.sv ----
// Static memory model on the far side of the port.
// Assumes strobes already gated by their enables.
`timescale 1ns/1ps
`default_nettype none
module embp_mem_model (
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  always @(posedge wr_n_i) mem[addr_i[7:0]] <= wdata_i;
  always @(posedge rd_n_i) last <= rdata_o;
  assign rdata_o = rd_n_i ? ~last : mem[addr_i[7:0]];
endmodule : embp_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench for embp_port with a memory model.
// Assumes a 20 MHz clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import embp_pkg::*;
  logic clock_i, rst_i, acc_req_i, acc_write_i, acc_prog_i, bus_request_in_n_i, acc_ready_o;
  logic [15:0] acc_addr_i, acc_wdata_i, rdata_o, ext_address_o, ext_data_i, ext_data_o;
  logic rdata_valid_o, bus_grant_out_n_o, ext_address_oe_o, ext_data_oe_o, access_select_n_o;
  logic space_select_o, space_select_oe_o, periph_space_enable_n_o, periph_space_enable_n_oe_o;
  logic read_strobe_n_o, read_strobe_n_oe_o, write_strobe_n_o, write_strobe_n_oe_o;
  logic [1:0] phase_o;
  int n_errors, num_checks;
  embp_port i_dut (.*);
  embp_mem_model i_mem (.addr_i(ext_address_o), .wdata_i(ext_data_o),
    .rd_n_i(read_strobe_n_o | ~read_strobe_n_oe_o),
    .wr_n_i(write_strobe_n_o | ~write_strobe_n_oe_o), .rdata_o(ext_data_i));
  always #25 clock_i = ~clock_i;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic p, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(negedge clock_i);
    {acc_req_i, acc_write_i, acc_prog_i, acc_addr_i, acc_wdata_i} = {1'b1, w, p, a, d};
    for (k = 0; k < 20 && acc_ready_o !== 1'b1; k++) @(negedge clock_i);
    chk(16'(k < 20), 16'h0001);
    @(negedge clock_i);
    acc_req_i = 1'b0;
    @(negedge clock_i);
  endtask : acc
  task automatic t_rw;
    acc(1'b1, 1'b0, 16'h0055, 16'hA5C3);
    chk(16'(write_strobe_n_o), 16'h0000);
    chk(16'(space_select_o), 16'h0000);
    chk(16'(access_select_n_o), 16'h0000);
    acc(1'b0, 1'b0, 16'h0055, 16'h0000);
    chk(ext_address_o, 16'h0055);
    chk(16'(read_strobe_n_o), 16'h0000);
    repeat (2) @(negedge clock_i);
    chk(16'(rdata_valid_o), 16'h0001);
    chk(rdata_o, 16'hA5C3);
    repeat (6) @(negedge clock_i);
    chk(ext_address_o, 16'h0055);
    chk(16'(space_select_o), 16'h0001);
    chk(16'(ext_data_oe_o), 16'h0000);
  endtask : t_rw
  task automatic t_periph;
    logic [15:0] adr [4] = '{16'hFEFF, 16'hFF00, 16'hFF7F, 16'hFF80};
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, adr[i], 16'h0000);
      chk(16'(periph_space_enable_n_o), 16'(i == 0 || i == 3));
    end
    acc(1'b0, 1'b1, 16'hFF00, 16'h0000);
    chk(16'(periph_space_enable_n_o), 16'h0001);
  endtask : t_periph
  task automatic t_grant;
    int k;
    @(negedge clock_i);
    bus_request_in_n_i = 1'b0;
    for (k = 0; k < 20 && bus_grant_out_n_o !== 1'b0; k++) @(negedge clock_i);
    chk(16'(k < 20), 16'h0001);
    chk(16'(read_strobe_n_oe_o), 16'h0000);
    chk(16'(write_strobe_n_oe_o), 16'h0000);
    chk(16'(ext_address_oe_o), 16'h0000);
    chk(16'(access_select_n_o), 16'h0001);
    bus_request_in_n_i = 1'b1;
    repeat (12) @(negedge clock_i);
    chk(16'(bus_grant_out_n_o), 16'h0001);
  endtask : t_grant
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    {clock_i, rst_i, bus_request_in_n_i} = 3'b011;
    {acc_req_i, acc_write_i, acc_prog_i, acc_addr_i, acc_wdata_i} = '0;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    t_rw();
    t_periph();
    t_grant();
    conclude();
  end
  initial begin
    #100us;
    n_errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
